// >>> eem_host.sv
// Purpose: host controller that drives a byte-wide eeprom through its pins
// Assumes: one request at a time, erase voltage switched externally by eraseHv
// Notes: reads, byte writes, chip erase and a checkerboard fill
// ****************************************
// Notes on behaviour
// - byte write only with select low, output drive high, store low.
// - erase: select low, store low, erase voltage on output drive, data all high.
// - erase transitions are timed against store strobe edges, not select.
// - pattern fill: even rows 10101010, odd rows 01010101, 128 rows by 16.
// - after a write or erase wait the full internal cycle first.
// ****************************************
module eem_host
    import eem_pkg::*;
#(
    parameter int WRITE_WAIT = WR_CYCLE_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clkEn,
    input wire logic reqValid,
    input wire eem_req_t req,
    output logic reqReady,
    output logic rdValid,
    output logic [7:0] rdData,
    output logic busy,
    output eem_pins_t pins,
    output logic [7:0] byteLinesOut,
    output logic byteLinesOe,
    input wire logic [7:0] byteLinesIn
);
    // the wait counter is 24 bits wide, so longer waits cannot be served
    if (WRITE_WAIT < 1 || WRITE_WAIT > 2 ** 24 - 1) begin : g_badWait
        $error("eem_host: WRITE_WAIT out of range");
    end

    // ****************************************
    // state
    // ****************************************
    typedef enum logic [2:0] {
        IDLE,
        RD_ACCESS,
        WR_SETUP,
        WR_PULSE,
        WR_HOLD,
        WR_WAIT
    } eem_state_t;

    eem_state_t state;
    logic [23:0] count;
    eem_cmd_t cmd;
    logic fillRun;
    logic [10:0] fillAddr;
    logic [7:0] syncData;

    eem_sync #(
        .WIDTH(DATA_W)
    ) uSync (
        .clk(clk),
        .rst_b(rst_b),
        .clkEn(clkEn),
        .asyncIn(byteLinesIn),
        .syncOut(syncData)
    );

    // row is addr[10:4]; its low bit picks the pattern
    function automatic logic [7:0] fill_byte(input logic [10:0] a);
        fill_byte = a[COL_W] ? PAT_ODD : PAT_EVEN;
    endfunction : fill_byte

    // ****************************************
    // sequencer
    // ****************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= IDLE;
            count <= '0;
            cmd <= EEM_CMD_READ;
            reqReady <= 1'b0;
            rdValid <= 1'b0;
            rdData <= RESET_DATA;
            busy <= 1'b0;
            pins <= '{selectN: 1'b1, outDriveN: 1'b1, storeN: 1'b1, eraseHv: 1'b0, addr: '0};
            byteLinesOut <= RESET_DATA;
            byteLinesOe <= 1'b0;
        end else if (clkEn) begin
            rdValid <= 1'b0;
            case (state)
                IDLE: begin
                    // idle pins: select high, store high keeps the part inhibited
                    pins.selectN <= 1'b1;
                    pins.storeN <= 1'b1;
                    pins.outDriveN <= 1'b1;
                    pins.eraseHv <= 1'b0;
                    byteLinesOe <= 1'b0;
                    count <= '0;
                    if (fillRun) begin
                        cmd <= EEM_CMD_WRITE;
                        pins.addr <= fillAddr;
                        byteLinesOut <= fill_byte(fillAddr);
                        reqReady <= 1'b0;
                        busy <= 1'b1;
                        state <= WR_SETUP;
                    end else if (reqValid && reqReady) begin
                        reqReady <= 1'b0;
                        busy <= 1'b1;
                        pins.addr <= req.addr;
                        case (req.cmd)
                            EEM_CMD_READ: begin
                                cmd <= EEM_CMD_READ;
                                pins.selectN <= 1'b0;
                                pins.outDriveN <= 1'b0;
                                state <= RD_ACCESS;
                            end
                            EEM_CMD_ERASE: begin
                                cmd <= EEM_CMD_ERASE;
                                byteLinesOut <= ERASE_DATA;
                                state <= WR_SETUP;
                            end
                            EEM_CMD_PATTERN: begin
                                cmd <= EEM_CMD_WRITE;
                                busy <= 1'b1;
                                state <= IDLE;
                            end
                            default: begin
                                cmd <= EEM_CMD_WRITE;
                                byteLinesOut <= req.data;
                                state <= WR_SETUP;
                            end
                        endcase
                    end else begin
                        reqReady <= 1'b1;
                        busy <= fillRun;
                    end
                end
                RD_ACCESS: begin
                    // wait access time plus the synchroniser delay
                    if (count == 24'(ACCESS_CYC + SYNC_STAGES + 1)) begin
                        rdData <= syncData;
                        rdValid <= 1'b1;
                        pins.selectN <= 1'b1;
                        pins.outDriveN <= 1'b1;
                        state <= IDLE;
                    end else begin
                        count <= count + 24'h000001;
                    end
                end
                WR_SETUP: begin
                    // output drive high (or high voltage) before store falls
                    pins.selectN <= 1'b0;
                    pins.outDriveN <= 1'b1;
                    pins.eraseHv <= (cmd == EEM_CMD_ERASE);
                    byteLinesOe <= 1'b1;
                    if (count == 24'(SETUP_CYC)) begin
                        count <= '0;
                        pins.storeN <= 1'b0;
                        state <= WR_PULSE;
                    end else begin
                        count <= count + 24'h000001;
                    end
                end
                WR_PULSE: begin
                    if (count == 24'(WR_PULSE_CYC)) begin
                        count <= '0;
                        pins.storeN <= 1'b1;
                        state <= WR_HOLD;
                    end else begin
                        count <= count + 24'h000001;
                    end
                end
                WR_HOLD: begin
                    // select, voltage and data released only after store rises
                    if (count == 24'(SETUP_CYC)) begin
                        count <= '0;
                        pins.selectN <= 1'b1;
                        pins.eraseHv <= 1'b0;
                        byteLinesOe <= 1'b0;
                        state <= WR_WAIT;
                    end else begin
                        count <= count + 24'h000001;
                    end
                end
                WR_WAIT: begin
                    // no access until the internal cycle is surely over
                    if (count == 24'(WRITE_WAIT - 1)) begin
                        count <= '0;
                        state <= IDLE;
                    end else begin
                        count <= count + 24'h000001;
                    end
                end
                default: begin
                    state <= IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // checkerboard fill walker
    // ****************************************
    // kept apart so a host request can never disturb the address walk
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fillRun <= 1'b0;
            fillAddr <= '0;
        end else if (clkEn) begin
            if (state == IDLE && !fillRun && reqValid && reqReady && req.cmd == EEM_CMD_PATTERN) begin
                fillRun <= 1'b1;
                fillAddr <= '0;
            end else if (state == WR_WAIT && count == 24'(WRITE_WAIT - 1) && fillRun) begin
                fillAddr <= fillAddr + 11'h001;
                fillRun <= (fillAddr != 11'h7ff);
            end
        end
    end
endmodule : eem_host

// >>> eem_pkg.sv
// Purpose: shared constants and carrier types for the eeprom host controller
// Assumes: 50 MHz clk, byte-wide 2048 x 8 part driven through its pins
// Notes: times are in ns or us, cycle counts derive from them
package eem_pkg;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_NS = 20;
    localparam int ACCESS_NS = 450;
    localparam int WR_PULSE_NS = 175;
    localparam int SETUP_NS = 50;
    localparam int WR_CYCLE_US = 10000;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int WR_PULSE_CYC = (WR_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int WR_CYCLE_CYC = (WR_CYCLE_US * 1000 + CLK_NS - 1) / CLK_NS;
    // ****************************************
    // layout and values
    // ****************************************
    localparam int ADDR_W = 11;
    localparam int DATA_W = 8;
    localparam int COL_W = 4;
    localparam logic [7:0] PAT_EVEN = 8'haa;
    localparam logic [7:0] PAT_ODD = 8'h55;
    localparam logic [7:0] ERASE_DATA = 8'hff;
    localparam logic [7:0] RESET_DATA = 8'h00;
    localparam int SYNC_STAGES = 3;

    typedef enum logic [1:0] {
        EEM_CMD_READ,
        EEM_CMD_WRITE,
        EEM_CMD_ERASE,
        EEM_CMD_PATTERN
    } eem_cmd_t;

    typedef struct packed {
        eem_cmd_t cmd;
        logic [10:0] addr;
        logic [7:0] data;
    } eem_req_t;

    // pin group toward the memory
    typedef struct packed {
        logic selectN;
        logic outDriveN;
        logic storeN;
        logic eraseHv;
        logic [10:0] addr;
    } eem_pins_t;
endpackage : eem_pkg

// >>> eem_sync.sv
// Purpose: three-stage synchroniser with a settle check for pin inputs
// Assumes: input is asynchronous to clk
// Notes: output changes only when stages two and three agree
module eem_sync
    import eem_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clkEn,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    if (WIDTH < 1) begin : g_badWidth
        $error("eem_sync: WIDTH must be positive");
    end

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    // stage1 feeds stage2 alone
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else if (clkEn) begin
            stage1 <= asyncIn;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            syncOut <= '0;
        end else if (clkEn && stage2 == stage3) begin
            syncOut <= stage3;
        end
    end
endmodule : eem_sync

// >>> eem_dev_model.sv
// Purpose: behavioural 2048 x 8 memory answering the host pins
// Assumes: erase voltage is flagged by eraseHv
// Notes: writes land on the rising store edge; no internal busy time
module eem_dev_model
    import eem_pkg::*;
(
    input wire eem_pins_t pins,
    input wire logic dataOe,
    input wire logic [7:0] dataIn,
    output logic [7:0] dataOut
);
    logic [7:0] mem [0:2047];
    logic [7:0] last = 8'h00;
    logic rdMode;
    initial for (int i = 0; i < 2048; i++) mem[i] = 8'hff;
    assign rdMode = !pins.selectN && !pins.outDriveN && pins.storeN;
    always @* if (rdMode) last = mem[pins.addr];
    // floating lines show the inverse of the last byte so a stale value never passes
    assign dataOut = rdMode ? mem[pins.addr] : ~last;
    always @(posedge pins.storeN) begin
        if (!pins.selectN && pins.eraseHv && dataOe && dataIn == 8'hff) begin
            for (int i = 0; i < 2048; i++) mem[i] = 8'hff;
        end else if (!pins.selectN && pins.outDriveN && !pins.eraseHv && dataOe) begin
            mem[pins.addr] = dataIn;
        end
    end
endmodule : eem_dev_model

// >>> eem_host_checker.sv
// Purpose: pin sequencing assertions for eem_host
// Assumes: clkEn dropped only while no store pulse or read result is in flight
// Notes: pulse and wait figures are lower bounds
module eem_host_checker
    import eem_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic rdValid,
    input wire eem_pins_t pins,
    input wire logic [7:0] byteLinesOut,
    input wire logic byteLinesOe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ****
    // pin rules
    // ****
    property p_wrMode; $fell(pins.storeN) |-> !pins.selectN && pins.outDriveN; endproperty
    a_wrMode: assert property (p_wrMode) else $error("store strobe outside write mode");
    property p_pulse; $fell(pins.storeN) |-> !pins.storeN [*8]; endproperty
    a_pulse: assert property (p_pulse) else $error("store pulse too short");
    property p_eraseData; pins.eraseHv && !pins.storeN |-> byteLinesOe && byteLinesOut == 8'hff; endproperty
    a_eraseData: assert property (p_eraseData) else $error("erase data not all high");
    property p_hvEdge; $rose(pins.eraseHv) || $fell(pins.eraseHv) |-> pins.storeN; endproperty
    a_hvEdge: assert property (p_hvEdge) else $error("erase voltage moved inside store pulse");
    property p_hvSel; pins.eraseHv |-> !pins.selectN; endproperty
    a_hvSel: assert property (p_hvSel) else $error("erase voltage without select");
    property p_rdMode; !pins.selectN && !pins.outDriveN |-> pins.storeN && !byteLinesOe; endproperty
    a_rdMode: assert property (p_rdMode) else $error("read mode with store or drive");
    property p_oeSafe; byteLinesOe |-> pins.outDriveN; endproperty
    a_oeSafe: assert property (p_oeSafe) else $error("host drives while part outputs");
    property p_wait; $rose(pins.storeN) |-> ##[1:8] pins.selectN ##1 pins.selectN [*8]; endproperty
    a_wait: assert property (p_wait) else $error("access during write cycle");
    property p_rdPulse; rdValid |=> !rdValid; endproperty
    a_rdPulse: assert property (p_rdPulse) else $error("read valid longer than one cycle");
endmodule : eem_host_checker

// >>> eem_host_tb_top.sv
// Purpose: self-checking bench for eem_host with a memory model
// Assumes: 50 MHz clock, short write wait
// Notes: pattern fill dominates run time
module eem_host_tb_top
    import eem_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int WAIT_CYC = 8;
    logic clk, rst_b, clkEn, reqValid, reqReady, rdValid, busy, byteLinesOe;
    eem_req_t req;
    eem_pins_t pins;
    logic [7:0] rdData, byteLinesOut, byteLinesIn, got;
    int failures = 0;
    int totalChecks = 0;
    int cycles = 0;
    eem_host #(.WRITE_WAIT(WAIT_CYC)) uut (.clk(clk), .rst_b(rst_b), .clkEn(clkEn), .reqValid(reqValid),
        .req(req), .reqReady(reqReady), .rdValid(rdValid), .rdData(rdData), .busy(busy), .pins(pins),
        .byteLinesOut(byteLinesOut), .byteLinesOe(byteLinesOe), .byteLinesIn(byteLinesIn));
    eem_dev_model dev (.pins(pins), .dataOe(byteLinesOe), .dataIn(byteLinesOut), .dataOut(byteLinesIn));
    // ****
    // tasks
    // ****
    task automatic finish_test();
        $display("checks %0d failures %0d", totalChecks, failures);
        if (failures == 0 && totalChecks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // request held until the edge that samples reqReady high
    task automatic op(input eem_cmd_t cmd, input logic [10:0] addr, input logic [7:0] data);
        got = 8'hxx;
        while (reqReady !== 1'b1) begin
            @(posedge clk);
            #1;
        end
        req = '{cmd, addr, data};
        reqValid = 1'b1;
        @(posedge clk);
        #1;
        reqValid = 1'b0;
        while (reqReady !== 1'b1) begin
            @(posedge clk);
            #1;
            if (rdValid === 1'b1) got = rdData;
        end
    endtask : op
    task automatic t_erasedRead();
        op(EEM_CMD_READ, 11'h000, 8'h00);
        check(got, 8'hff);
        op(EEM_CMD_READ, 11'h7ff, 8'h00);
        check(got, 8'hff);
    endtask : t_erasedRead
    task automatic t_writeRead();
        op(EEM_CMD_WRITE, 11'h123, 8'h5a);
        op(EEM_CMD_WRITE, 11'h124, 8'ha5);
        op(EEM_CMD_READ, 11'h123, 8'h00);
        check(got, 8'h5a);
        op(EEM_CMD_READ, 11'h124, 8'h00);
        check(got, 8'ha5);
        op(EEM_CMD_WRITE, 11'h123, 8'hff);
        op(EEM_CMD_READ, 11'h123, 8'h00);
        check(got, 8'hff);
    endtask : t_writeRead
    task automatic t_erase();
        op(EEM_CMD_ERASE, 11'h000, 8'hff);
        op(EEM_CMD_READ, 11'h124, 8'h00);
        check(got, 8'hff);
    endtask : t_erase
    task automatic t_pattern();
        logic [10:0] addrs [4] = '{11'h000, 11'h01f, 11'h7e5, 11'h7ff};
        logic [7:0] want [4] = '{8'haa, 8'h55, 8'haa, 8'h55};
        op(EEM_CMD_PATTERN, 11'h000, 8'h00);
        check({7'h00, busy}, 8'h00);
        for (int i = 0; i < 4; i++) begin
            op(EEM_CMD_READ, addrs[i], 8'h00);
            check(got, want[i]);
        end
    endtask : t_pattern
    // clock enable low must hold a read in flight well past its normal answer time
    task automatic t_freeze();
        op(EEM_CMD_WRITE, 11'h055, 8'h3c);
        got = 8'hxx;
        req = '{EEM_CMD_READ, 11'h055, 8'h00};
        reqValid = 1'b1;
        @(posedge clk);
        #1;
        reqValid = 1'b0;
        clkEn = 1'b0;
        repeat (40) @(posedge clk);
        #1;
        check({7'h00, busy}, 8'h01);
        check({7'h00, reqReady}, 8'h00);
        check({7'h00, rdValid}, 8'h00);
        clkEn = 1'b1;
        while (reqReady !== 1'b1) begin
            @(posedge clk);
            #1;
            if (rdValid === 1'b1) got = rdData;
        end
        check(got, 8'h3c);
        check({7'h00, busy}, 8'h00);
    endtask : t_freeze
    // ****
    // run
    // ****
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 95000) begin
            failures++;
            finish_test();
        end
    end
    initial begin
        rst_b = 1'b0;
        reqValid = 1'b0;
        req = '0;
        clkEn = 1'b1;
        repeat (5) @(posedge clk);
        #1;
        rst_b = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        t_erasedRead();
        t_writeRead();
        t_erase();
        t_pattern();
        t_freeze();
        finish_test();
    end
endmodule : eem_host_tb_top
bind eem_host eem_host_checker chk (.clk(clk), .rst_b(rst_b), .rdValid(rdValid), .pins(pins),
    .byteLinesOut(byteLinesOut), .byteLinesOe(byteLinesOe));
